//--- hw/tidc_map.svh
// constants of the transceiver id and diagnostics block: timings, bus codes, memory layout
`ifndef TIDC_MAP_SVH
`define TIDC_MAP_SVH
// core clock and time conversion
`define TIDC_CLK_HZ 50000000
`define TIDC_MS_CYC(ms) ((ms) * (`TIDC_CLK_HZ / 1000))
`define TIDC_US_CYC(us) ((us) * (`TIDC_CLK_HZ / 1000000))
// longest times and fastest bus clock, in their own units
`define TIDC_T_OFF_US 10
`define TIDC_T_ON_US 30
`define TIDC_T_INIT_MS 300
`define TIDC_T_LOSS_ON_US 100
`define TIDC_T_LOSS_OFF_US 350
`define TIDC_T_SOFT_MS 100
`define TIDC_T_DATA_MS 1000
`define TIDC_T_SERIAL_MS 300
`define TIDC_T_WRITE_MS 10
`define TIDC_F_SCL_KHZ 400
// derived cycle counts (longest times round down)
`define TIDC_INIT_CYC `TIDC_MS_CYC(`TIDC_T_INIT_MS)
`define TIDC_DATA_CYC `TIDC_MS_CYC(`TIDC_T_DATA_MS)
`define TIDC_SERIAL_CYC `TIDC_MS_CYC(`TIDC_T_SERIAL_MS)
// two-wire device addresses (7 bit)
`define TIDC_ID_DEV 7'h50
`define TIDC_DIAG_DEV 7'h51
// identification memory offsets and values
`define TIDC_A_TYPE 7'h00
`define TIDC_V_TYPE 8'h03
`define TIDC_A_EXT 7'h01
`define TIDC_V_EXT 8'h04
`define TIDC_A_CONN 7'h02
`define TIDC_V_CONN 8'h07
`define TIDC_A_ETH 7'h06
`define TIDC_V_ETH 8'h20
`define TIDC_A_ENC 7'h0B
`define TIDC_V_ENC 8'h02
`define TIDC_A_RATE 7'h0C
`define TIDC_V_RATE 8'h01
`define TIDC_A_LEN_A 7'h10
`define TIDC_A_LEN_B 7'h11
`define TIDC_V_LEN 8'hC8
`define TIDC_A_NAME 7'h14
`define TIDC_A_ORG 7'h25
`define TIDC_A_PN 7'h28
`define TIDC_A_REV 7'h38
`define TIDC_V_SPACE 8'h20
`define TIDC_A_WAVE 7'h3C
`define TIDC_V_WAVE 16'h051E
`define TIDC_A_BSUM 7'h3F
`define TIDC_A_OPT 7'h41
`define TIDC_V_OPT 8'h12
`define TIDC_A_SN 7'h44
`define TIDC_A_DATE 7'h54
`define TIDC_A_DMT 7'h5C
`define TIDC_V_DMT 8'h68
`define TIDC_A_ENH 7'h5D
`define TIDC_V_ENH 8'hD0
`define TIDC_A_DCL 7'h5E
`define TIDC_V_DCL 8'h06
`define TIDC_A_XSUM 7'h5F
// diagnostics page offsets and status bits
`define TIDC_D_TEMP 8'h60
`define TIDC_D_VCC 8'h62
`define TIDC_D_BIAS 8'h64
`define TIDC_D_TXP 8'h66
`define TIDC_D_RXP 8'h68
`define TIDC_D_STAT 8'h6E
`define TIDC_B_TXST 7
`define TIDC_B_SOFT 6
`define TIDC_B_LOS 1
`define TIDC_B_RDY 0
`endif

//--- hw/tidc_pkg.sv
// types of the transceiver id and diagnostics block
package tidc_pkg;
  typedef logic [7:0] tidc_byte_t;
  typedef enum logic [3:0] {
    TIDC_IDLE, TIDC_DEV, TIDC_DEV_ACK, TIDC_WORD, TIDC_WORD_ACK,
    TIDC_WR, TIDC_WR_ACK, TIDC_RD, TIDC_RD_ACK
  } tidc_bus_st_t;
endpackage

//--- hw/tidc_top.sv
// transceiver management: two-wire id/diag slave, transmit-off and signal-lost control
// Operation
// - hardware off pin kills emitter within 10 us
// - off pin release restores emitter within 30 us
// - emitter on within 300 ms after power
// - signal lost output asserts within 100 us
// - signal lost output clears within 350 us
// - soft off bit kills emitter quickly
// - clearing soft off restores emitter quickly
// - soft lost bit follows signal both ways
// - data ready bit set within 1000 ms
// - serial access answered after 300 ms
// - writes complete within 10 ms of stop
// - checksum bytes 63 and 95 fixed
// - bytes 68-83 hold unique serial number
// - bytes 84-91 hold date code
// - wavelength 0x051E at bytes 60-61
// - options byte 65 reads 0x12
// - bytes 92, 93 read 0x68, 0xD0
// - transmit power derived from bias current
// - temperature reported as case temperature
// - status lost bit mirrors output pin
// - soft off bit readable and writable
`timescale 1ns/10ps
`include "tidc_map.svh"
module tidc_top #(
  parameter int unsigned INIT_CYC   = `TIDC_INIT_CYC,   // power-up to emitter on
  parameter int unsigned SERIAL_CYC = `TIDC_SERIAL_CYC, // power-up to bus answer
  parameter int unsigned DATA_CYC   = `TIDC_DATA_CYC,   // power-up to forced ready
  parameter logic [127:0] VENDOR_NAME = {16{8'h20}},   // arbitrary neutral text
  parameter logic [23:0]  VENDOR_ORG  = 24'h000000,    // arbitrary value
  parameter logic [127:0] PART_NUMBER = {16{8'h20}},   // arbitrary neutral text
  parameter logic [127:0] SERIAL_NUM  = {16{8'h30}},   // set per module
  parameter logic [63:0]  DATE_CODE   = {8{8'h30}},    // set per lot
  parameter logic [7:0]   TXP_GAIN    = 8'h10,         // power per bias, /256
  parameter logic [15:0]  TEMP_OFS    = 16'h0000       // case minus internal
) (
  // clock and power-on reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // two-wire management bus, open drain data
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_n,
  // hardware transmit-off pin and emitter drive
  input  wire logic                hw_transmit_off_input,
  output logic                     tx_emit_en,
  // receiver signal detect and lost pin
  input  wire logic                rx_signal_present,
  output logic                     signal_lost_output,
  // analogue monitor samples, core clock domain
  input  wire logic                mon_valid,
  input  wire logic [15:0]         mon_temp_int,
  input  wire logic [15:0]         mon_vcc,
  input  wire logic [15:0]         mon_bias,
  input  wire logic [15:0]         mon_rx_power,
  // status echo
  output logic                     data_ready
);
  import tidc_pkg::*;
  // raw identification byte, checksums excluded
  function automatic tidc_pkg::tidc_byte_t id_raw(input logic [6:0] a);
    int i;
    i = int'(a);
    if (a == `TIDC_A_TYPE) return `TIDC_V_TYPE;
    if (a == `TIDC_A_EXT) return `TIDC_V_EXT;
    if (a == `TIDC_A_CONN) return `TIDC_V_CONN;
    if (a == `TIDC_A_ETH) return `TIDC_V_ETH;
    if (a == `TIDC_A_ENC) return `TIDC_V_ENC;
    if (a == `TIDC_A_RATE) return `TIDC_V_RATE;
    if (a == `TIDC_A_LEN_A || a == `TIDC_A_LEN_B) return `TIDC_V_LEN;
    // text and code fields, first byte most significant
    if (a >= `TIDC_A_NAME && a < `TIDC_A_NAME + 7'd16)
      return VENDOR_NAME[8*(15-(i-int'(`TIDC_A_NAME))) +: 8];
    if (a >= `TIDC_A_ORG && a < `TIDC_A_ORG + 7'd3)
      return VENDOR_ORG[8*(2-(i-int'(`TIDC_A_ORG))) +: 8];
    if (a >= `TIDC_A_PN && a < `TIDC_A_PN + 7'd16)
      return PART_NUMBER[8*(15-(i-int'(`TIDC_A_PN))) +: 8];
    if (a >= `TIDC_A_REV && a < `TIDC_A_REV + 7'd4) return `TIDC_V_SPACE;
    if (a == `TIDC_A_WAVE) return 8'(`TIDC_V_WAVE >> 8);
    if (a == `TIDC_A_WAVE + 7'd1) return 8'(`TIDC_V_WAVE);
    if (a == `TIDC_A_OPT) return `TIDC_V_OPT;
    if (a >= `TIDC_A_SN && a < `TIDC_A_SN + 7'd16)
      return SERIAL_NUM[8*(15-(i-int'(`TIDC_A_SN))) +: 8];
    if (a >= `TIDC_A_DATE && a < `TIDC_A_DATE + 7'd8)
      return DATE_CODE[8*(7-(i-int'(`TIDC_A_DATE))) +: 8];
    if (a == `TIDC_A_DMT) return `TIDC_V_DMT;
    if (a == `TIDC_A_ENH) return `TIDC_V_ENH;
    if (a == `TIDC_A_DCL) return `TIDC_V_DCL;
    return 8'h00;
  endfunction
  // byte sum over a range of the identification memory
  function automatic tidc_pkg::tidc_byte_t id_sum(input int lo, input int hi);
    tidc_pkg::tidc_byte_t s;
    s = 8'h00;
    for (int k = lo; k <= hi; k++) begin
      s = 8'(s + id_raw(7'(k)));
    end
    return s;
  endfunction
  // checksums fold to constants: nothing can change the image after build
  localparam tidc_byte_t BASE_SUM = id_sum(0, 62);
  localparam tidc_byte_t EXT_SUM  = id_sum(64, 94);
  // synchronisers for pins from outside the clock domain
  logic [1:0] scl_sync_reg;    // serial clock
  logic [1:0] sda_sync_reg;    // serial data
  logic [1:0] off_sync_reg;    // hardware off pin
  logic [1:0] sig_sync_reg;    // signal detect
  logic       scl_d_reg;       // previous synced clock
  logic       sda_d_reg;       // previous synced data
  logic       scl_s;           // synced clock
  logic       sda_s;           // synced data
  logic       hw_off_s;        // synced off pin
  logic       sig_s;           // synced signal detect
  // two flops per pin, second flop is the only reader of the first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      off_sync_reg <= 2'h3;
      sig_sync_reg <= 2'h0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      off_sync_reg <= {off_sync_reg[0], hw_transmit_off_input};
      sig_sync_reg <= {sig_sync_reg[0], rx_signal_present};
      scl_d_reg    <= scl_s;
      sda_d_reg    <= sda_s;
    end
  end
  assign scl_s    = scl_sync_reg[1];
  assign sda_s    = sda_sync_reg[1];
  assign hw_off_s = off_sync_reg[1];
  assign sig_s    = sig_sync_reg[1];
  logic scl_rise;  // host sampling edge
  logic scl_fall;  // edge after which data may change
  logic bus_start; // data falls while clock high
  logic bus_stop;  // data rises while clock high

  // both lines pass equal delay, so their order is kept
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // power-up timer, saturates at the longest of the power-up times
  logic [25:0] pwr_cnt_reg; // cycles since reset release
  logic        init_done;   // emitter may light
  logic        serial_ok;   // bus transfers answered
  logic        ready_time;  // monitors forced ready
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_cnt_reg <= 26'h0000000;
    end else if (pwr_cnt_reg < 26'(DATA_CYC)) begin
      pwr_cnt_reg <= pwr_cnt_reg + 26'h0000001;
    end
  end
  assign init_done  = pwr_cnt_reg >= 26'(INIT_CYC);
  assign serial_ok  = pwr_cnt_reg >= 26'(SERIAL_CYC);
  assign ready_time = pwr_cnt_reg >= 26'(DATA_CYC);
  // bus engine state
  tidc_bus_st_t st_reg;      // transfer phase
  tidc_byte_t   sh_reg;      // shift register, both directions
  logic [3:0]   bit_cnt_reg; // sampled bits in this byte
  logic         drv_low_reg; // pull data line low
  logic         rd_reg;      // transfer is a read
  logic         page_reg;    // 0 id memory, 1 diagnostics
  tidc_byte_t   ptr_reg;     // byte pointer, auto increments
  logic         wr_en_reg;   // one-cycle write strobe
  tidc_byte_t   wr_adr_reg;  // write strobe address
  tidc_byte_t   wr_dat_reg;  // write strobe data
  logic         dev_hit;     // address byte selects us
  tidc_byte_t   rd_byte;     // byte at the pointer
  assign dev_hit = serial_ok && (sh_reg[7:1] == `TIDC_ID_DEV || sh_reg[7:1] == `TIDC_DIAG_DEV);
  // control and monitor state
  logic         soft_off_reg;  // soft transmit-off bit
  logic         lost_reg;      // signal lost, pin and status
  logic         ready_reg;     // data ready bit
  logic [15:0]  temp_reg;      // case temperature
  logic [15:0]  vcc_reg;       // supply sample
  logic [15:0]  bias_reg;      // bias sample
  logic [15:0]  txp_reg;       // inferred transmit power
  logic [15:0]  rxp_reg;       // receive power sample
  logic [23:0]  txp_prod;      // bias times gain
  // read mux for both pages
  always_comb begin
    rd_byte = 8'h00;
    if (!page_reg) begin
      if (ptr_reg[7]) rd_byte = 8'h00;
      else if (ptr_reg[6:0] == `TIDC_A_BSUM) rd_byte = BASE_SUM;
      else if (ptr_reg[6:0] == `TIDC_A_XSUM) rd_byte = EXT_SUM;
      else rd_byte = id_raw(ptr_reg[6:0]);
    end else begin
      unique case (ptr_reg)
        `TIDC_D_TEMP:         rd_byte = temp_reg[15:8];
        `TIDC_D_TEMP + 8'h01: rd_byte = temp_reg[7:0];
        `TIDC_D_VCC:          rd_byte = vcc_reg[15:8];
        `TIDC_D_VCC + 8'h01:  rd_byte = vcc_reg[7:0];
        `TIDC_D_BIAS:         rd_byte = bias_reg[15:8];
        `TIDC_D_BIAS + 8'h01: rd_byte = bias_reg[7:0];
        `TIDC_D_TXP:          rd_byte = txp_reg[15:8];
        `TIDC_D_TXP + 8'h01:  rd_byte = txp_reg[7:0];
        `TIDC_D_RXP:          rd_byte = rxp_reg[15:8];
        `TIDC_D_RXP + 8'h01:  rd_byte = rxp_reg[7:0];
        `TIDC_D_STAT: begin
          // status byte, reserved bits read zero
          rd_byte[`TIDC_B_TXST] = hw_off_s;
          rd_byte[`TIDC_B_SOFT] = soft_off_reg;
          rd_byte[`TIDC_B_LOS]  = lost_reg;
          rd_byte[`TIDC_B_RDY]  = ready_reg;
        end
        default: rd_byte = 8'h00;
      endcase
    end
  end
  // bus engine: start and stop win over any phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg      <= TIDC_IDLE;
      sh_reg      <= 8'h00;
      bit_cnt_reg <= 4'h0;
      drv_low_reg <= 1'b0;
      rd_reg      <= 1'b0;
      page_reg    <= 1'b0;
      ptr_reg     <= 8'h00;
    end else if (bus_start) begin
      st_reg      <= TIDC_DEV;
      bit_cnt_reg <= 4'h0;
      drv_low_reg <= 1'b0;
    end else if (bus_stop) begin
      st_reg      <= TIDC_IDLE;
      drv_low_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        TIDC_IDLE: begin
          drv_low_reg <= 1'b0;
        end
        TIDC_DEV, TIDC_WORD, TIDC_WR: begin
          // sample on rise, answer after the eighth bit
          if (scl_rise) begin
            sh_reg      <= {sh_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            drv_low_reg <= 1'b1;
            if (st_reg == TIDC_DEV) begin
              // unknown device or too early: stay off the bus
              drv_low_reg <= dev_hit;
              st_reg      <= dev_hit ? TIDC_DEV_ACK : TIDC_IDLE;
              rd_reg      <= sh_reg[0];
              page_reg    <= sh_reg[1];
            end else if (st_reg == TIDC_WORD) begin
              ptr_reg <= sh_reg;
              st_reg  <= TIDC_WORD_ACK;
            end else begin
              // data byte acked even on the id page
              ptr_reg <= ptr_reg + 8'h01;
              st_reg  <= TIDC_WR_ACK;
            end
          end
        end
        TIDC_DEV_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rd_reg) begin
              sh_reg      <= rd_byte;
              drv_low_reg <= ~rd_byte[7];
              st_reg      <= TIDC_RD;
            end else begin
              drv_low_reg <= 1'b0;
              st_reg      <= TIDC_WORD;
            end
          end
        end
        TIDC_WORD_ACK, TIDC_WR_ACK: begin
          if (scl_fall) begin
            drv_low_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            st_reg      <= TIDC_WR;
          end
        end
        TIDC_RD: begin
          // host samples on rise, next bit goes out on fall
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              drv_low_reg <= 1'b0;
              ptr_reg     <= ptr_reg + 8'h01;
              st_reg      <= TIDC_RD_ACK;
            end else begin
              sh_reg      <= {sh_reg[6:0], 1'b0};
              drv_low_reg <= ~sh_reg[6];
            end
          end
        end
        TIDC_RD_ACK: begin
          // a not-acknowledge ends the read
          if (scl_rise && sda_s) begin
            st_reg <= TIDC_IDLE;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            sh_reg      <= rd_byte;
            drv_low_reg <= ~rd_byte[7];
            st_reg      <= TIDC_RD;
          end
        end
        default: st_reg <= TIDC_IDLE;
      endcase
    end
  end

  // write strobe, raised once per data byte received for the diagnostics page
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_en_reg  <= 1'b0;
      wr_adr_reg <= 8'h00;
      wr_dat_reg <= 8'h00;
    end else begin
      wr_en_reg <= 1'b0;
      if (!bus_start && !bus_stop && st_reg == TIDC_WR && scl_fall && bit_cnt_reg == 4'h8) begin
        wr_en_reg  <= page_reg;
        wr_adr_reg <= ptr_reg;
        wr_dat_reg <= sh_reg;
      end
    end
  end

  // soft off bit; takes effect at the byte ack, long before the stop deadline
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_off_reg <= 1'b0;
    end else if (wr_en_reg && wr_adr_reg == `TIDC_D_STAT) begin
      soft_off_reg <= wr_dat_reg[`TIDC_B_SOFT];
    end
  end

  // emitter drive: a few cycles from pin or bit to light off or on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_emit_en <= 1'b0;
    end else begin
      tx_emit_en <= init_done & ~hw_off_s & ~soft_off_reg;
    end
  end

  // signal lost: one flop feeds pin and status bit so they never disagree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lost_reg <= 1'b1;
    end else begin
      lost_reg <= ~sig_s;
    end
  end

  assign signal_lost_output = lost_reg;
  // data ready once monitors run, or at the latest when time is up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_reg <= 1'b0;
    end else if (mon_valid || ready_time) begin
      ready_reg <= 1'b1;
    end
  end

  assign data_ready = ready_reg;
  // gain product, top bits kept as the power figure
  assign txp_prod = mon_bias * TXP_GAIN;
  // monitor snapshot; values only move while the samples are valid
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_reg <= 16'h0000;
      vcc_reg  <= 16'h0000;
      bias_reg <= 16'h0000;
      txp_reg  <= 16'h0000;
      rxp_reg  <= 16'h0000;
    end else if (mon_valid) begin
      temp_reg <= 16'(mon_temp_int + TEMP_OFS);
      vcc_reg  <= mon_vcc;
      bias_reg <= mon_bias;
      txp_reg  <= txp_prod[23:8];
      rxp_reg  <= mon_rx_power;
    end
  end

  // open drain data: output value is always low, enable does the work
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drv_low_reg;

endmodule

//--- bench/tidc_host_model.sv
// host-side two-wire master model of the id/diag block
`timescale 1ns/10ps
module tidc_host_model (
  // time base
  input  wire logic clk,
  // wired data level
  input  wire logic sda_w,
  // host clock and data release (1 = pull-up wins)
  output logic      scl,
  output logic      sda_rel
);
  import tidc_pkg::*;
  // bus idles high on both lines
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end
  // quarter bit of 2 core clocks: 160 ns bus clock
  task automatic q();
    repeat (2) @(posedge clk);
  endtask
  // start or repeated start
  task automatic start();
    q();
    sda_rel <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_rel <= 1'b0;
    q();
    scl <= 1'b0;
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    q();
    sda_rel <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_rel <= 1'b1;
    q();
  endtask
  // eight bits plus the acknowledge slot, msb first
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      q();
      sda_rel <= tx[i];
      q();
      scl <= 1'b1;
      q();
      rx[i] = sda_w;
      q();
      scl <= 1'b0;
    end
  endtask
  // one-byte write, ok if all bytes acked
  task automatic wr(input logic [6:0] dev, input tidc_byte_t ptr, input tidc_byte_t d, output logic ok);
    logic [8:0] r0, r1, r2;
    start();
    xfer({dev, 1'b0, 1'b1}, r0);
    xfer({ptr, 1'b1}, r1);
    xfer({d, 1'b1}, r2);
    stop();
    ok = !r0[0] && !r1[0] && !r2[0];
  endtask
  // random read of n bytes, the last nacked
  task automatic rd(input logic [6:0] dev, input tidc_byte_t ptr, input int n, output tidc_byte_t d[$],
                    output logic ok);
    logic [8:0] r0, r1, r2, r;
    d = {};
    start();
    xfer({dev, 1'b0, 1'b1}, r0);
    xfer({ptr, 1'b1}, r1);
    start();
    xfer({dev, 1'b1, 1'b1}, r2);
    for (int k = 0; k < n; k++) begin
      xfer({8'hFF, k == n - 1}, r);
      d.push_back(r[8:1]);
    end
    stop();
    ok = !r0[0] && !r1[0] && !r2[0];
  endtask
endmodule

//--- bench/tidc_top_asserts.sv
// concurrent checks on the ports of the id/diag block
`timescale 1ns/10ps
module tidc_top_asserts #(
  parameter int unsigned INIT_CYC   = 200,
  parameter int unsigned SERIAL_CYC = 200,
  parameter int unsigned DATA_CYC   = 400
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_oe_n,
  // transmit and receive pins
  input wire logic hw_transmit_off_input,
  input wire logic tx_emit_en,
  input wire logic rx_signal_present,
  input wire logic signal_lost_output,
  // monitor strobe and ready echo
  input wire logic mon_valid,
  input wire logic data_ready
);
  logic [31:0] cyc_reg; // cycles since reset release, saturating
  logic        lit_reg; // emitter state while the off pin was last low
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // power-up timer, saturating so it never wraps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_reg <= '0;
    end else if (cyc_reg < DATA_CYC + 16) begin
      cyc_reg <= cyc_reg + 32'h1;
    end
  end
  // light state before an off pulse began
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lit_reg <= 1'b0;
    end else if (!hw_transmit_off_input) begin
      lit_reg <= tx_emit_en;
    end
  end
  pin_off_a: assert property (hw_transmit_off_input [*8] |-> !tx_emit_en)
    else $error("emitter still on after off pin");
  pin_on_a: assert property ($fell(hw_transmit_off_input) && lit_reg |-> ##[1:8] tx_emit_en)
    else $error("emitter not back after off pin release");
  init_emit_a: assert property ((!hw_transmit_off_input) [*8] ##0 (cyc_reg == INIT_CYC + 8) |-> tx_emit_en)
    else $error("emitter not on after init time");
  init_dark_a: assert property (cyc_reg < INIT_CYC |-> !tx_emit_en)
    else $error("emitter on during init");
  lost_on_a: assert property ((!rx_signal_present) [*6] |-> signal_lost_output)
    else $error("lost output late");
  lost_off_a: assert property (rx_signal_present [*6] |-> !signal_lost_output)
    else $error("lost output not cleared");
  ready_sample_a: assert property (mon_valid |-> ##[1:3] data_ready)
    else $error("ready not set by sample");
  ready_time_a: assert property (cyc_reg > DATA_CYC + 4 |-> data_ready)
    else $error("ready not set by timer");
  quiet_early_a: assert property (cyc_reg < SERIAL_CYC |-> sda_oe_n)
    else $error("bus answered too early");
  sda_edge_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data moved while bus clock high");
  cover property ($fell(tx_emit_en));
  cover property ($rose(signal_lost_output));
  cover property ($fell(sda_oe_n));
  cover property ($rose(data_ready));
endmodule
bind tidc_top tidc_top_asserts #(.INIT_CYC(INIT_CYC), .SERIAL_CYC(SERIAL_CYC), .DATA_CYC(DATA_CYC)) i_chk (
  .clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
  .hw_transmit_off_input(hw_transmit_off_input), .tx_emit_en(tx_emit_en),
  .rx_signal_present(rx_signal_present), .signal_lost_output(signal_lost_output),
  .mon_valid(mon_valid), .data_ready(data_ready)
);

//--- bench/tidc_top_test.sv
// self-checking bench of the transceiver id/diag block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); \
  end \
end
module tidc_top_test;
  import tidc_pkg::*;
  localparam int unsigned INIT = 200; // short power-up for simulation
  localparam int unsigned DATA = 400;
  localparam logic [127:0] SN = 128'h30313233343536373839414243444546;
  localparam logic [63:0]  DC = 64'h3230323430313032;
  localparam logic [79:0]  MON = {16'h1334, 16'h8001, 16'h0200, 16'h0020, 16'h0ABC}; // temp+0x100, bias*0x10/256
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hw_off = 1'b0;
  logic        rx_ok = 1'b1;
  logic        mon_valid = 1'b0;
  logic [15:0] m_temp = '0, m_vcc = '0, m_bias = '0, m_rxp = '0;
  logic        scl, sda_rel, sda_out, sda_oe_n, sda_w, tx_emit_en, lost, data_ready, ok;
  int          error_cnt = 0;
  int          checked = 0;
  tidc_byte_t  q[$];
  tidc_byte_t  s0, s1;
  // id rows: address, then byte
  logic [15:0] rows [16] = '{16'h0003, 16'h0104, 16'h0207, 16'h0620, 16'h0B02, 16'h0C01, 16'h10C8, 16'h11C8,
                             16'h3C05, 16'h3D1E, 16'h4112, 16'h5C68, 16'h5DD0, 16'h5E06, 16'h6000, 16'h7F00};
  always #10 clk = ~clk;
  // open-drain data line with pull-up
  assign sda_w = sda_rel & (sda_oe_n | sda_out);
  tidc_top #(.INIT_CYC(INIT), .SERIAL_CYC(INIT), .DATA_CYC(DATA), .SERIAL_NUM(SN), .DATE_CODE(DC),
             .TXP_GAIN(8'h10), .TEMP_OFS(16'h0100)) i_dut (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .hw_transmit_off_input(hw_off), .tx_emit_en(tx_emit_en), .rx_signal_present(rx_ok),
    .signal_lost_output(lost), .mon_valid(mon_valid), .mon_temp_int(m_temp), .mon_vcc(m_vcc),
    .mon_bias(m_bias), .mon_rx_power(m_rxp), .data_ready(data_ready));
  tidc_host_model i_host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_rel(sda_rel));
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog, some six times the expected run
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK("dark in init", 1'b0, tx_emit_en)
    i_host.wr(7'h50, 8'h00, 8'h00, ok);
    `CHK("early ack", 1'b0, ok)
    repeat (INIT) @(posedge clk);
    `CHK("lit after init", 1'b1, tx_emit_en)
    i_host.wr(7'h52, 8'h00, 8'h00, ok);
    `CHK("foreign dev", 1'b0, ok)
    // whole id page in one read
    i_host.rd(7'h50, 8'h00, 128, q, ok);
    `CHK("id ack", 1'b1, ok)
    foreach (rows[i]) begin
      `CHK("id byte", rows[i][7:0], q[rows[i][15:8]])
    end
    s0 = '0;
    s1 = '0;
    for (int i = 0; i < 95; i++) begin
      s0 += (i < 63) ? q[i] : 8'h00;
      s1 += (i > 63) ? q[i] : 8'h00;
    end
    `CHK("base sum", s0, q[63])
    `CHK("ext sum", s1, q[95])
    for (int i = 0; i < 16; i++) begin
      `CHK("serial", SN[127-8*i -: 8], q[68 + i])
      if (i < 8) `CHK("date", DC[63-8*i -: 8], q[84 + i])
    end
    `CHK("ready by timer", 1'b1, data_ready)
    tend("id page");
    // id page write is acked but ignored
    i_host.wr(7'h50, 8'h41, 8'hFF, ok);
    `CHK("id wr ack", 1'b1, ok)
    i_host.rd(7'h50, 8'h41, 1, q, ok);
    `CHK("id kept", 8'h12, q[0])
    // soft off, read back, soft on
    i_host.wr(7'h51, 8'h6E, 8'h40, ok);
    repeat (8) @(posedge clk);
    `CHK("soft off", 1'b0, tx_emit_en)
    i_host.rd(7'h51, 8'h6E, 1, q, ok);
    `CHK("status soft", 8'h41, q[0])
    i_host.wr(7'h51, 8'h6E, 8'h00, ok);
    repeat (8) @(posedge clk);
    `CHK("soft on", 1'b1, tx_emit_en)
    tend("soft off");
    // hardware off pin, with status echo
    @(posedge clk) hw_off <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("hw off", 1'b0, tx_emit_en)
    i_host.rd(7'h51, 8'h6E, 1, q, ok);
    `CHK("status hw", 8'h81, q[0])
    @(posedge clk) hw_off <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("hw on", 1'b1, tx_emit_en)
    tend("hw off");
    // loss and return of signal
    @(posedge clk) rx_ok <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("lost pin", 1'b1, lost)
    i_host.rd(7'h51, 8'h6E, 1, q, ok);
    `CHK("status lost", 8'h03, q[0])
    @(posedge clk) rx_ok <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("lost clear", 1'b0, lost)
    i_host.rd(7'h51, 8'h6E, 1, q, ok);
    `CHK("status back", 8'h01, q[0])
    tend("signal lost");
    // monitor sample, msb-first pairs
    @(posedge clk) begin
      mon_valid <= 1'b1;
      m_temp <= 16'h1234;
      m_vcc <= 16'h8001;
      m_bias <= 16'h0200;
      m_rxp <= 16'h0ABC;
    end
    @(posedge clk) mon_valid <= 1'b0;
    i_host.rd(7'h51, 8'h60, 10, q, ok);
    for (int i = 0; i < 10; i++) begin
      `CHK("monitor", MON[79 - 8*i -: 8], q[i])
    end
    tend("monitors");
    // second reset, then ready from a sample
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("reset ready", 1'b0, data_ready)
    `CHK("reset lost", 1'b1, lost)
    `CHK("reset dark", 1'b0, tx_emit_en)
    @(posedge clk) arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(posedge clk) mon_valid <= 1'b1;
    @(posedge clk) mon_valid <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("ready on sample", 1'b1, data_ready)
    tend("reset");
    summarize();
  end
endmodule
